// ### pkg/fxu_consts.svh
// constants for the fixed-point compare and leading-zero-count datapath
// Functional notes
// - signed register compare, opcode 31/xo 0, sets one ordering bit in chosen field.
// - signed immediate compare, opcode 11, sign-extends 16-bit immediate, signed compare.
// - unsigned register compare, opcode 31/xo 32, sets one ordering bit.
// - unsigned immediate compare, opcode 10, zero-extends 16-bit immediate, unsigned compare.
// - field bits: 0 less, 1 greater, 2 match, 3 copy of summary overflow.
// - 3-bit field selector picks field 0-7; other fields, field zero included, untouched.
// - compares never touch the exception register; no record or overflow forms.
// - count leading zeros of 64-bit source from the top; result 0 to 64.
// - count decodes as opcode 31/xo 58, bits 16-20 zero, bit 31 record.
// - on a 32-bit implementation the count raises illegal-instruction instead.
// - record form writes field zero, less always cleared, match when count zero.
`ifndef FXU_CONSTS_SVH
`define FXU_CONSTS_SVH

// instruction field positions (bit 0 of the word is the lsb)
`define PRIMARY_HI        31
`define PRIMARY_LO        26
`define FIELD_SEL_HI      25
`define FIELD_SEL_LO      23
`define SIZE_BIT          21
`define SRC_B_HI          15
`define SRC_B_LO          11
`define EXT_OP_HI         10
`define EXT_OP_LO         1
`define RECORD_BIT        0
`define IMM_HI            15
`define IMM_LO            0

// opcodes
`define OPC_EXTENDED      6'd31
`define OPC_SIGNED_IMM    6'd11
`define OPC_UNSIGNED_IMM  6'd10
`define XO_SIGNED_REG     10'd0
`define XO_UNSIGNED_REG   10'd32
`define XO_LZC_DW         10'd58
`define LZC_RSVD_FIELD    5'h00

// register map
`define OFF_CTRL          12'h000
`define OFF_COND_STATE    12'h004
`define OFF_ILLEGAL_COUNT 12'h008
`define CTRL_WIDE_BIT     0
`define CTRL_RESET        32'h0000_0001
`define COND_RESET        32'h0000_0000

`endif

// ### pkg/fxu_pkg.sv
// types for the fixed-point compare and leading-zero-count datapath
package fxu_pkg;

  typedef struct packed {
    logic less_flag;
    logic greater_flag;
    logic match_flag;
    logic summary_overflow;
  } cond_field_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] source_reg_a;
    logic [63:0] source_reg_b;
    logic [63:0] source_reg_s;
    logic        summary_overflow;
  } issue_req_t;

  typedef struct packed {
    logic        valid;
    logic        illegal_instr;
    logic        gpr_write_en;
    logic [63:0] gpr_write_data;
    logic        cond_write_en;
    logic [2:0]  cond_write_sel;
  } issue_rsp_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SIGNED_REG,
    OP_SIGNED_IMM,
    OP_UNSIGNED_REG,
    OP_UNSIGNED_IMM,
    OP_LZC_DW
  } fxu_op_t;

endpackage

// ### hw/lead_zero_count.sv
// leading-zero counter, msb first
`timescale 1ns/100ps
module lead_zero_count #(
  parameter int W = 64
) (
  // data in
  input  wire logic [W-1:0]           data,
  // count out
  output logic      [$clog2(W+1)-1:0] count
);

  always_comb begin
    count = ($clog2(W+1))'(W);
    for (int i = 0; i < W; i++) begin
      if (data[i]) begin
        count = ($clog2(W+1))'(W - 1 - i);
      end
    end
  end

endmodule

// ### hw/magnitude_compare.sv
// three-way magnitude comparator, signed or unsigned
`timescale 1ns/100ps
module magnitude_compare #(
  parameter int W = 64
) (
  // operands
  input  wire logic [W-1:0] op_a,
  input  wire logic [W-1:0] op_b,
  input  wire logic         signed_mode,
  // ordering
  output logic              less,
  output logic              greater,
  output logic              equal
);

  logic top_flip;

  always_comb begin
    // flipping both sign bits turns a signed order into an unsigned one
    top_flip = signed_mode;
    equal    = (op_a == op_b);
    less     = ({op_a[W-1] ^ top_flip, op_a[W-2:0]} < {op_b[W-1] ^ top_flip, op_b[W-2:0]});
    greater  = !equal && !less;
  end

endmodule

// ### hw/fxu_compare_clz.sv
// fixed-point compare and leading-zero-count datapath with apb control
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "fxu_consts.svh"
module fxu_compare_clz
  import fxu_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // issue side
  input  wire issue_req_t  issue_req,
  output issue_rsp_t       issue_rsp,
  output logic [31:0]      cond_reg,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  // reset release
  logic [1:0] reset_sync;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_sync <= 2'h0;
    end else begin
      reset_sync <= {reset_sync[0], 1'b1};
    end
  end

  assign rst_n = reset_sync[1];

  // instruction fields
  logic [5:0]  primary_op;
  logic [9:0]  ext_op;
  logic [2:0]  target_cond_field;
  logic        size_bit;
  logic        record_bit;
  logic [4:0]  src_b_field;
  logic [15:0] imm_field;

  assign primary_op        = issue_req.instr[`PRIMARY_HI:`PRIMARY_LO];
  assign ext_op            = issue_req.instr[`EXT_OP_HI:`EXT_OP_LO];
  assign target_cond_field = issue_req.instr[`FIELD_SEL_HI:`FIELD_SEL_LO];
  assign size_bit          = issue_req.instr[`SIZE_BIT];
  assign record_bit        = issue_req.instr[`RECORD_BIT];
  assign src_b_field       = issue_req.instr[`SRC_B_HI:`SRC_B_LO];
  assign imm_field         = issue_req.instr[`IMM_HI:`IMM_LO];

  // control state
  logic        wide_mode;
  logic [31:0] illegal_count;

  // decode
  fxu_op_t     op;
  logic        op_signed;
  logic [63:0] cmp_a;
  logic [63:0] cmp_b;
  logic [63:0] operand_two;
  logic        full_width;

  always_comb begin
    op = OP_NONE;
    if (issue_req.valid) begin
      if (primary_op == `OPC_SIGNED_IMM) begin
        op = OP_SIGNED_IMM;
      end else if (primary_op == `OPC_UNSIGNED_IMM) begin
        op = OP_UNSIGNED_IMM;
      end else if (primary_op == `OPC_EXTENDED) begin
        if (ext_op == `XO_SIGNED_REG) begin
          op = OP_SIGNED_REG;
        end else if (ext_op == `XO_UNSIGNED_REG) begin
          op = OP_UNSIGNED_REG;
        end else if (ext_op == `XO_LZC_DW && src_b_field == `LZC_RSVD_FIELD) begin
          op = OP_LZC_DW;
        end
      end
    end
  end

  always_comb begin
    op_signed = (op == OP_SIGNED_REG) || (op == OP_SIGNED_IMM);
    // second operand: register, sign-extended or zero-extended immediate
    case (op)
      OP_SIGNED_IMM:   operand_two = {{48{imm_field[15]}}, imm_field};
      OP_UNSIGNED_IMM: operand_two = {48'h0000_0000_0000, imm_field};
      default:         operand_two = issue_req.source_reg_b;
    endcase
    // narrow compare unless a wide core is asked for a doubleword one
    full_width = wide_mode && size_bit;
    if (full_width) begin
      cmp_a = issue_req.source_reg_a;
      cmp_b = operand_two;
    end else if (op_signed) begin
      cmp_a = {{32{issue_req.source_reg_a[31]}}, issue_req.source_reg_a[31:0]};
      cmp_b = {{32{operand_two[31]}}, operand_two[31:0]};
    end else begin
      cmp_a = {32'h0000_0000, issue_req.source_reg_a[31:0]};
      cmp_b = {32'h0000_0000, operand_two[31:0]};
    end
  end

  // datapath units
  logic       cmp_less;
  logic       cmp_greater;
  logic       cmp_equal;
  logic [6:0] lzc_count;

  magnitude_compare #(
    .W (64)
  ) u_compare (
    .op_a        (cmp_a),
    .op_b        (cmp_b),
    .signed_mode (op_signed),
    .less        (cmp_less),
    .greater     (cmp_greater),
    .equal       (cmp_equal)
  );

  lead_zero_count #(
    .W (64)
  ) u_lzc (
    .data  (issue_req.source_reg_s),
    .count (lzc_count)
  );

  // result and condition register
  cond_field_t cmp_field;
  cond_field_t lzc_field;
  logic        is_compare;
  logic        lzc_legal;
  logic [7:0]  field_hit;
  issue_rsp_t  next_issue_rsp;
  logic [31:0] next_cond_reg;
  logic [31:0] next_illegal_count;

  // instruction class
  always_comb begin
    is_compare = (op == OP_SIGNED_REG) || (op == OP_SIGNED_IMM) ||
                 (op == OP_UNSIGNED_REG) || (op == OP_UNSIGNED_IMM);
    lzc_legal  = (op == OP_LZC_DW) && wide_mode;
  end

  // field images of the two writers
  always_comb begin
    cmp_field.less_flag        = cmp_less;
    cmp_field.greater_flag     = cmp_greater;
    cmp_field.match_flag       = cmp_equal;
    cmp_field.summary_overflow = issue_req.summary_overflow;
    lzc_field.less_flag        = 1'b0;
    lzc_field.greater_flag     = (lzc_count != 7'h00);
    lzc_field.match_flag       = (lzc_count == 7'h00);
    lzc_field.summary_overflow = issue_req.summary_overflow;
  end

  // one write strobe per field; one issue a cycle, so writers never collide
  always_comb begin
    field_hit = 8'h00;
    if (is_compare) begin
      field_hit[target_cond_field] = 1'b1;
    end
    if (lzc_legal && record_bit) begin
      field_hit[0] = 1'b1;
    end
  end

  // only the selected field changes, written at the issue edge
  always_comb begin
    next_cond_reg = cond_reg;
    for (int f = 0; f < 8; f++) begin
      if (field_hit[f]) begin
        next_cond_reg[31 - 4*f -: 4] = is_compare ? cmp_field : lzc_field;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_reg <= `COND_RESET;
    end else begin
      cond_reg <= next_cond_reg;
    end
  end

  // response, one cycle per recognised issue
  always_comb begin
    next_issue_rsp                = '0;
    next_issue_rsp.valid          = (op != OP_NONE);
    next_issue_rsp.illegal_instr  = (op == OP_LZC_DW) && !wide_mode;
    next_issue_rsp.gpr_write_en   = lzc_legal;
    next_issue_rsp.gpr_write_data = lzc_legal ? {57'h0, lzc_count} : 64'h0;
    // no exception-register update path exists for compares
    next_issue_rsp.cond_write_en  = is_compare || (lzc_legal && record_bit);
    next_issue_rsp.cond_write_sel = is_compare ? target_cond_field : 3'h0;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      issue_rsp <= '0;
    end else begin
      issue_rsp <= next_issue_rsp;
    end
  end

  // illegal-instruction counter, wraps
  always_comb begin
    next_illegal_count = illegal_count;
    if (next_issue_rsp.illegal_instr) begin
      next_illegal_count = illegal_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_count <= 32'h0000_0000;
    end else begin
      illegal_count <= next_illegal_count;
    end
  end

  // apb slave: one wait state, write lands on the completing edge
  logic        access_wait;
  logic        write_fire;
  logic [11:0] reg_addr;
  logic        addr_hit;
  logic        sel_ctrl;
  logic        sel_cond;
  logic        sel_count;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        next_wide_mode;

  // register select
  always_comb begin
    reg_addr  = paddr[11:0];
    addr_hit  = (paddr[31:12] == 20'h00000);
    sel_ctrl  = addr_hit && (reg_addr == `OFF_CTRL);
    sel_cond  = addr_hit && (reg_addr == `OFF_COND_STATE);
    sel_count = addr_hit && (reg_addr == `OFF_ILLEGAL_COUNT);
  end

  // bus answer, built in the first access cycle
  always_comb begin
    access_wait  = psel && penable && !pready;
    next_pready  = access_wait;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (access_wait) begin
      if (sel_ctrl) begin
        next_prdata = {31'h0, wide_mode};
      end else if (sel_cond) begin
        next_prdata = cond_reg;
      end else if (sel_count) begin
        next_prdata = illegal_count;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // mode bit; an error completion never writes
  always_comb begin
    write_fire     = psel && penable && pready && pwrite && !pslverr;
    next_wide_mode = wide_mode;
    if (write_fire && sel_ctrl && pstrb[0]) begin
      next_wide_mode = pwdata[`CTRL_WIDE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wide_mode <= 1'(`CTRL_RESET);
    end else begin
      wide_mode <= next_wide_mode;
    end
  end

endmodule

// ### test/fxu_compare_clz_assertions.sv
// port checker for the compare and count datapath
`timescale 1ns/100ps
`include "fxu_consts.svh"
module fxu_compare_clz_assertions
  import fxu_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // issue side
  input wire issue_req_t  issue_req,
  input wire issue_rsp_t  issue_rsp,
  input wire logic [31:0] cond_reg,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready
);
  logic [2:0]  sel;
  logic [3:0]  fld;
  logic [31:0] keep;
  logic        is_imm;
  logic        is_lzc;
  assign sel    = issue_rsp.cond_write_sel;
  assign fld    = cond_reg[5'd31 - {sel, 2'b00} -: 4];
  assign keep   = ~(32'hf000_0000 >> {sel, 2'b00});
  assign is_imm = issue_req.valid && issue_req.instr[31:27] == 5'b00101;
  assign is_lzc = issue_req.valid && issue_req.instr[31:26] == `OPC_EXTENDED
                  && issue_req.instr[10:1] == `XO_LZC_DW && issue_req.instr[15:11] == 5'h00;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_imm_sel;
    is_imm |=> issue_rsp.valid && issue_rsp.cond_write_en && sel == $past(issue_req.instr[25:23]);
  endproperty
  a_imm_sel: assert property (p_imm_sel) else $error("wrong field chosen");
  property p_one_order;
    issue_rsp.cond_write_en |-> $onehot(fld[3:1]);
  endproperty
  a_one_order: assert property (p_one_order) else $error("ordering bits not one-hot");
  property p_so_copy;
    issue_rsp.cond_write_en |-> fld[0] == $past(issue_req.summary_overflow);
  endproperty
  a_so_copy: assert property (p_so_copy) else $error("overflow copy wrong");
  property p_others_kept;
    issue_rsp.cond_write_en |-> ((cond_reg ^ $past(cond_reg)) & keep) == 32'h0;
  endproperty
  a_others_kept: assert property (p_others_kept) else $error("other field changed");
  property p_quiet;
    !issue_rsp.cond_write_en |-> $stable(cond_reg);
  endproperty
  a_quiet: assert property (p_quiet) else $error("field changed without write");
  property p_lzc_zero;
    is_lzc && issue_req.source_reg_s == 64'h0 |=>
      !issue_rsp.gpr_write_en || issue_rsp.gpr_write_data == 64'd64;
  endproperty
  a_lzc_zero: assert property (p_lzc_zero) else $error("zero source count wrong");
  property p_lzc_record;
    issue_rsp.gpr_write_en && issue_rsp.cond_write_en |->
      sel == 3'd0 && !fld[3] && fld[1] == (issue_rsp.gpr_write_data == 64'h0);
  endproperty
  a_lzc_record: assert property (p_lzc_record) else $error("record field wrong");
  property p_illegal;
    issue_rsp.illegal_instr |-> issue_rsp.valid && !issue_rsp.gpr_write_en
                               && !issue_rsp.cond_write_en;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal count wrote state");
  property p_lzc_answer;
    is_lzc |=> issue_rsp.valid && (issue_rsp.gpr_write_en ^ issue_rsp.illegal_instr);
  endproperty
  a_lzc_answer: assert property (p_lzc_answer) else $error("count not answered");
  property p_rsp_cause;
    issue_rsp.valid |-> $past(issue_req.valid);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without issue");
  property p_apb_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
  c_illegal: cover property (issue_rsp.illegal_instr);
  c_record: cover property (issue_rsp.gpr_write_en && issue_rsp.cond_write_en);
  c_b2b: cover property (is_imm ##1 issue_req.valid);
endmodule

// ### test/issue_stage.sv
// issue pipeline model feeding the compare and count datapath
`timescale 1ns/100ps
module issue_stage
  import fxu_pkg::*;
(
  // clock
  input wire logic        core_clk,
  // datapath side
  output issue_req_t      issue_req,
  input wire issue_rsp_t  issue_rsp,
  input wire logic [31:0] cond_reg
);
  logic [102:0] log_q[$];
  initial issue_req = '0;
  // answers with the field state they left
  always @(posedge core_clk) begin
    if (issue_rsp.valid === 1'b1) begin
      log_q.push_back({issue_rsp, cond_reg});
    end
  end
  // one instruction per slot, back to back
  task automatic send(input logic [31:0] i, input logic [63:0] a, b, input logic so);
    issue_req <= '{1'b1, i, a, b, a, so};
    @(posedge core_clk);
  endtask
  // idle slot: stale operands not left showing
  task automatic idle();
    issue_req <= '{1'b0, ~issue_req.instr, ~issue_req.source_reg_a,
                   ~issue_req.source_reg_b, ~issue_req.source_reg_s, 1'b0};
    @(posedge core_clk);
  endtask
endmodule

// ### test/tb_top.sv
// testbench for the compare and count datapath
`timescale 1ns/100ps
`include "fxu_consts.svh"
module tb_top
  import fxu_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  issue_req_t  issue_req;
  issue_rsp_t  issue_rsp;
  logic [31:0] cond_reg, paddr, pwdata, prdata, rd, exp_cond;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [3:0]  pstrb;
  logic [31:0] ins [6];
  logic [63:0] av [6];
  logic [63:0] bv [6];
  logic [3:0]  ef [6];
  logic [63:0] lz_s [4] = '{64'h0, 64'h0061_9920, 64'h8000_0000_0000_0000, 64'h1};
  logic [6:0]  lz_n [4] = '{7'd64, 7'd41, 7'd0, 7'd63};
  logic        lz_r [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  int          n_mismatch, samples_checked;
  always #12.5 core_clk = ~core_clk;
  fxu_compare_clz fxu_compare_clz_i (.core_clk(core_clk), .reset_n(reset_n),
    .issue_req(issue_req), .issue_rsp(issue_rsp), .cond_reg(cond_reg), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  issue_stage issue_stage_i (.core_clk(core_clk), .issue_req(issue_req),
    .issue_rsp(issue_rsp), .cond_reg(cond_reg));
  function automatic logic [31:0] cmpw(logic [5:0] op, logic [2:0] fsel, logic l,
                                       logic [15:0] lo);
    return {op, fsel, 1'b0, l, 5'd0, lo};
  endfunction
  function automatic logic [31:0] lzw(logic [4:0] rsv, logic rec);
    return {`OPC_EXTENDED, 10'd0, rsv, `XO_LZC_DW, rec};
  endfunction
  task automatic check(input string nm, input logic [102:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, wd);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_mismatch++;
    @(posedge core_clk);
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic e_err,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, 103'({err, rd}), 103'({e_err, e}));
  endtask
  task automatic pop(input string nm, input issue_rsp_t r);
    logic [102:0] got;
    got = issue_stage_i.log_q.size() > 0 ? issue_stage_i.log_q.pop_front() : '0;
    check(nm, got, {r, exp_cond});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, exp_cond} = '0;
    pstrb = 4'hf;
    ins = '{cmpw(6'd31, 3'd0, 1'b1, {5'd0, `XO_SIGNED_REG, 1'b0}),
            cmpw(6'd11, 3'd5, 1'b1, 16'hffff), cmpw(6'd31, 3'd3, 1'b0,
            {5'd0, `XO_UNSIGNED_REG, 1'b1}), cmpw(6'd10, 3'd7, 1'b1, 16'h8000),
            cmpw(6'd31, 3'd0, 1'b1, 16'h0), cmpw(6'd11, 3'd2, 1'b1, 16'h0011)};
    av = '{64'hffff_ffff_ffff_ffe7, '1, 64'hffff_0000, 64'h7fff, 64'h5, 64'h8000_0000};
    bv = '{64'h11, 64'h0, 64'h1_7fff_0000, 64'h0, 64'h5, 64'h0};
    ef = '{4'h8, 4'h3, 4'h4, 4'h9, 4'h2, 4'h5};
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rchk("ctrl reset", `OFF_CTRL, 1'b0, 32'h1);
    rchk("unmapped", 32'h10, 1'b1, 32'h0);
    for (int i = 0; i < 6; i++) issue_stage_i.send(ins[i], av[i], bv[i], ef[i][0]);
    issue_stage_i.idle();
    issue_stage_i.idle();
    for (int i = 0; i < 6; i++) begin
      exp_cond[5'd31 - {ins[i][25:23], 2'b00} -: 4] = ef[i];
      pop("compare", '{1'b1, 1'b0, 1'b0, 64'h0, 1'b1, ins[i][25:23]});
    end
    apb(1'b1, `OFF_COND_STATE, 32'hffff_ffff);
    rchk("cond state", `OFF_COND_STATE, 1'b0, exp_cond);
    for (int i = 0; i < 4; i++) issue_stage_i.send(lzw(5'd0, lz_r[i]), lz_s[i], ~lz_s[i], lz_r[i]);
    issue_stage_i.send(lzw(5'h01, 1'b1), 64'h0, 64'h0, 1'b0);
    issue_stage_i.idle();
    issue_stage_i.idle();
    for (int i = 0; i < 4; i++) begin
      if (lz_r[i]) exp_cond[31:28] = {1'b0, lz_n[i] != 0, lz_n[i] == 0, 1'b1};
      pop("count", '{1'b1, 1'b0, 1'b1, 64'(lz_n[i]), lz_r[i], 3'd0});
    end
    check("reserved", 103'(issue_stage_i.log_q.size()), 103'd0);
    apb(1'b1, `OFF_CTRL, 32'h0);
    issue_stage_i.send(lzw(5'd0, 1'b1), 64'h0, 64'h0, 1'b0);
    issue_stage_i.send(cmpw(6'd31, 3'd1, 1'b0, {5'd0, `XO_SIGNED_REG, 1'b0}), 64'h8000_0000,
                       64'h1, 1'b0);
    issue_stage_i.idle();
    issue_stage_i.idle();
    pop("illegal", '{1'b1, 1'b1, 1'b0, 64'h0, 1'b0, 3'd0});
    exp_cond[27:24] = 4'h8;
    pop("narrow signed", '{1'b1, 1'b0, 1'b0, 64'h0, 1'b1, 3'd1});
    rchk("illegal count", `OFF_ILLEGAL_COUNT, 1'b0, 32'h1);
    results();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
endmodule
bind fxu_compare_clz fxu_compare_clz_assertions fxu_compare_clz_assertions_i (
  .core_clk(core_clk), .reset_n(reset_n), .issue_req(issue_req), .issue_rsp(issue_rsp),
  .cond_reg(cond_reg), .psel(psel), .penable(penable), .pready(pready));
